// ---- common/stiu_pkg.sv ----
// store unit package: encodings, field positions, size and mode codes
// assumes a single core clock and a decoded-operand pipeline on one side
package stiu_pkg;
	// ************************************************
	// major opcodes and fields
	// ************************************************
	localparam logic [4:0] STIU_MAJ_GEN      = 5'h04;
	localparam logic [4:0] STIU_MAJ_MEM32    = 5'h03;
	localparam logic [4:0] STIU_MAJ_CLONG    = 5'h14;
	localparam logic [4:0] STIU_MAJ_CBYTE    = 5'h15;
	localparam logic [4:0] STIU_MAJ_CHALF    = 5'h16;
	localparam logic [4:0] STIU_MAJ_CSP      = 5'h18;
	localparam logic [5:0] STIU_SUB_AUXW     = 6'h2b;
	localparam logic [1:0] STIU_MODE_COND    = 2'h3;
	localparam logic [5:0] STIU_LIMM_REG     = 6'h3e;
	localparam logic [2:0] STIU_CSP_LONG     = 3'h2;
	localparam logic [2:0] STIU_CSP_BYTE     = 3'h3;
	localparam logic [4:0] STIU_SP_REG       = 5'h1c;
	localparam int         STIU_OPMODE_LSB   = 22;
	localparam int         STIU_SUBOP_LSB    = 16;
	localparam int         STIU_FLAG_BIT     = 15;
	// ************************************************
	// size and base update codes
	// ************************************************
	localparam logic [1:0] STIU_SZ_LONG      = 2'h0;
	localparam logic [1:0] STIU_SZ_BYTE      = 2'h1;
	localparam logic [1:0] STIU_SZ_HALF      = 2'h2;
	localparam logic [1:0] STIU_UPD_NONE     = 2'h0;
	localparam logic [1:0] STIU_UPD_PRE      = 2'h1;
	localparam logic [1:0] STIU_UPD_POST     = 2'h2;
	localparam logic [1:0] STIU_UPD_SCALED   = 2'h3;
	typedef enum logic [1:0] {STIU_ERR_NONE, STIU_ERR_COND, STIU_ERR_FMT} stiu_err_t;
endpackage

// ---- common/stiu_if.sv ----
// interface joining the store unit to memory and auxiliary register space
// assumes the far end answers every request with ready in the same or later cycle
interface stiu_if;
	import stiu_pkg::*;
	logic        mem_valid;
	logic        mem_ready;
	logic [31:0] mem_addr;
	logic [31:0] mem_data;
	logic [1:0]  mem_size;
	logic        mem_bypass;
	logic        aux_valid;
	logic        aux_ready;
	logic [31:0] aux_num;
	logic [31:0] aux_data;
	modport unit (output mem_valid, mem_addr, mem_data, mem_size, mem_bypass,
		aux_valid, aux_num, aux_data, input mem_ready, aux_ready);
	modport target (input mem_valid, mem_addr, mem_data, mem_size, mem_bypass,
		aux_valid, aux_num, aux_data, output mem_ready, aux_ready);
endinterface

// ---- rtl/stiu_target.sv ----
// far end: memory and auxiliary register target with a small store array
// assumes requests are held stable until ready; answers ready at once
module stiu_target
	import stiu_pkg::*;
#(
	parameter int AUX_DEPTH = 16
) (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	stiu_if.target           bus,
	output logic             wr_seen_o,
	output logic [31:0]      last_addr_o,
	output logic [31:0]      last_data_o,
	output logic [1:0]       last_size_o,
	output logic             last_bypass_o,
	output logic             misalign_o
);
	typedef struct packed {
		logic        seen;
		logic [31:0] addr;
		logic [31:0] data;
		logic [1:0]  size;
		logic        bypass;
		logic        misalign;
	} stiu_tgt_t;
	stiu_tgt_t st_r;
	stiu_tgt_t st_nxt;
	logic [31:0] aux_mem_r [AUX_DEPTH];

	// ************************************************
	// always ready: no wait states modelled here
	// ************************************************
	assign bus.mem_ready = 1'b1;
	assign bus.aux_ready = 1'b1;

	// capture last store; flag alignment breaches
	always_comb begin
		st_nxt = st_r;
		st_nxt.seen = bus.mem_valid | bus.aux_valid;
		if (bus.mem_valid) begin
			st_nxt.addr = bus.mem_addr;
			st_nxt.data = bus.mem_data;
			st_nxt.size = bus.mem_size;
			st_nxt.bypass = bus.mem_bypass;
			st_nxt.misalign = (bus.mem_size == STIU_SZ_HALF && bus.mem_addr[0]) ||
				(bus.mem_size == STIU_SZ_LONG && bus.mem_addr[1:0] != 2'h0);
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// auxiliary storage; no reset needed for data words
	always_ff @(posedge clk_i) begin
		if (bus.aux_valid) begin
			aux_mem_r[bus.aux_num[$clog2(AUX_DEPTH)-1:0]] <= bus.aux_data;
		end
	end

	assign wr_seen_o     = st_r.seen;
	assign last_addr_o   = st_r.addr;
	assign last_data_o   = st_r.data;
	assign last_size_o   = st_r.size;
	assign last_bypass_o = st_r.bypass;
	assign misalign_o    = st_r.misalign;
endmodule

// ---- rtl/stiu_unit.sv ----
// store unit: decodes store instructions and issues memory or aux writes
// assumes the pipeline supplies register values and a following long immediate
module stiu_unit
	import stiu_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        inst_valid_i,
	input  wire logic [31:0] inst_i,
	input  wire logic        inst_compact_i,
	input  wire logic [31:0] limm_i,
	input  wire logic [31:0] reg_b_i,
	input  wire logic [31:0] reg_c_i,
	output logic             inst_ready_o,
	output logic             inst_done_o,
	output logic             err_o,
	output logic [1:0]       err_kind_o,
	output logic             wb_valid_o,
	output logic [4:0]       wb_reg_o,
	output logic [31:0]      wb_data_o,
	output logic             flags_write_o,
	output logic [4:0]       b_sel_o,
	output logic [4:0]       c_sel_o,
	stiu_if.unit             bus
);
	typedef enum logic [1:0] {STIU_IDLE, STIU_MEM, STIU_AUX} stiu_state_t;
	typedef struct packed {
		stiu_state_t state;
		logic [31:0] addr;
		logic [31:0] data;
		logic [1:0]  size;
		logic        bypass;
		logic        done;
		logic        err;
		logic [1:0]  err_kind;
		logic        wb;
		logic [4:0]  wb_reg;
		logic [31:0] wb_data;
		logic [1:0]  upd;
	} stiu_st_t;
	stiu_st_t st_r;
	stiu_st_t st_nxt;

	// ************************************************
	// field extraction
	// ************************************************
	logic [4:0]  major;
	logic [4:0]  cmaj;
	logic [5:0]  c_fld;
	logic [5:0]  sub_op;
	logic [1:0]  op_mode;
	logic        is_aux;
	logic        is_mem;
	logic        is_cmp;
	logic [31:0] src1;
	logic [31:0] src2;
	logic [31:0] base;
	logic [31:0] offs;
	logic [31:0] scaled;
	logic [31:0] sum;
	logic [31:0] ea;
	logic [1:0]  sz;
	logic [1:0]  upd;
	logic        bad_fmt;

	assign major   = inst_i[31:27];
	assign cmaj    = inst_i[15:11];
	assign sub_op  = inst_i[STIU_SUBOP_LSB+5:STIU_SUBOP_LSB];
	assign op_mode = inst_i[STIU_OPMODE_LSB+1:STIU_OPMODE_LSB];
	assign c_fld   = inst_i[11:6];
	assign is_aux = !inst_compact_i && major == STIU_MAJ_GEN && sub_op == STIU_SUB_AUXW;
	assign is_mem = !inst_compact_i && major == STIU_MAJ_MEM32;
	assign is_cmp = inst_compact_i && (cmaj == STIU_MAJ_CLONG || cmaj == STIU_MAJ_CBYTE ||
		cmaj == STIU_MAJ_CHALF || (cmaj == STIU_MAJ_CSP &&
		(inst_i[7:5] == STIU_CSP_LONG || inst_i[7:5] == STIU_CSP_BYTE)));

	// register selects for the pipeline operand fetch
	always_comb begin
		b_sel_o = '0;
		c_sel_o = '0;
		if (inst_compact_i) begin
			b_sel_o = (cmaj == STIU_MAJ_CSP) ? STIU_SP_REG : {2'h0, inst_i[10:8]};
			c_sel_o = (cmaj == STIU_MAJ_CSP) ? {2'h0, inst_i[10:8]} : {2'h0, inst_i[7:5]};
		end else begin
			// selects are five bits wide: registers 32 and up are out of reach
			b_sel_o = {inst_i[13:12], inst_i[26:24]};
			c_sel_o = c_fld[4:0];
		end
	end

	// operand, size and offset selection
	always_comb begin
		src1 = reg_c_i;
		src2 = reg_c_i;
		base = reg_b_i;
		offs = '0;
		sz   = STIU_SZ_LONG;
		upd  = STIU_UPD_NONE;
		bad_fmt = 1'b0;
		if (is_aux) begin
			// limm as data or aux number
			src1 = ({inst_i[14:12], inst_i[26:24]} == STIU_LIMM_REG) ? limm_i : reg_b_i;
			case (op_mode)
				2'h0: src2 = (c_fld == STIU_LIMM_REG) ? limm_i : reg_c_i;
				2'h1: src2 = {26'h0, c_fld};
				2'h2: src2 = {{20{inst_i[5]}}, inst_i[5:0], c_fld};
				default: src2 = reg_c_i;
			endcase
		end else if (is_mem) begin
			src1 = (c_fld == STIU_LIMM_REG) ? limm_i : reg_c_i;
			base = ({inst_i[14:12], inst_i[26:24]} == STIU_LIMM_REG) ? limm_i : reg_b_i;
			offs = {{23{inst_i[15]}}, inst_i[15], inst_i[23:16]};
			sz   = inst_i[2:1];
			upd  = inst_i[4:3];
			bad_fmt = (sz == 2'h3) || (upd == STIU_UPD_SCALED && sz == STIU_SZ_BYTE);
		end else if (is_cmp) begin
			src1 = reg_c_i;
			case (cmaj)
				STIU_MAJ_CLONG: offs = {25'h0, inst_i[4:0], 2'h0};
				STIU_MAJ_CBYTE: begin
					offs = {27'h0, inst_i[4:0]};
					sz = STIU_SZ_BYTE;
				end
				STIU_MAJ_CHALF: begin
					offs = {26'h0, inst_i[4:0], 1'b0};
					sz = STIU_SZ_HALF;
				end
				default: begin
					offs = {25'h0, inst_i[4:0], 2'h0};
					sz = (inst_i[7:5] == STIU_CSP_BYTE) ? STIU_SZ_BYTE : STIU_SZ_LONG;
				end
			endcase
		end
	end

	// ************************************************
	// dedicated address adder
	// ************************************************
	// scale offset by data size
	assign scaled = (upd != STIU_UPD_SCALED) ? offs :
		(sz == STIU_SZ_HALF) ? {offs[30:0], 1'b0} : {offs[29:0], 2'h0};
	// independent adder, carry dropped; 32-bit arithmetic
	assign sum = 32'(base + scaled);
	assign ea  = (upd == STIU_UPD_POST) ? base : sum;

	// ************************************************
	// sequencing
	// ************************************************
	assign inst_ready_o = (st_r.state == STIU_IDLE);

	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.err  = 1'b0;
		st_nxt.wb   = 1'b0;
		case (st_r.state)
			STIU_IDLE: begin
				if (inst_valid_i && is_aux) begin
					if (op_mode == STIU_MODE_COND) begin
						st_nxt.err = 1'b1;
						st_nxt.err_kind = STIU_ERR_COND;
						st_nxt.done = 1'b1;
					end else begin
						// aux number and data; reserved bits unused
						st_nxt.addr  = src2;
						st_nxt.data  = src1;
						st_nxt.state = STIU_AUX;
					end
				end else if (inst_valid_i && (is_mem || is_cmp)) begin
					if (bad_fmt) begin
						st_nxt.err = 1'b1;
						st_nxt.err_kind = STIU_ERR_FMT;
						st_nxt.done = 1'b1;
					end else begin
						st_nxt.addr   = ea;
						st_nxt.data   = src1;
						st_nxt.size   = sz;
						st_nxt.bypass = is_mem & inst_i[5];
						// base update for codes one, two only
						st_nxt.wb_reg  = b_sel_o;
						st_nxt.wb_data = sum;
						// a long immediate base has no register to update
						st_nxt.upd = (is_mem && {inst_i[14:12], inst_i[26:24]} != STIU_LIMM_REG) ?
							upd : STIU_UPD_NONE;
						st_nxt.state  = STIU_MEM;
					end
				end
			end
			STIU_MEM: begin
				if (bus.mem_ready) begin
					st_nxt.done  = 1'b1;
					st_nxt.wb    = (st_r.upd == STIU_UPD_PRE || st_r.upd == STIU_UPD_POST);
					st_nxt.state = STIU_IDLE;
				end
			end
			STIU_AUX: begin
				if (bus.aux_ready) begin
					st_nxt.done  = 1'b1;
					st_nxt.state = STIU_IDLE;
				end
			end
			default: st_nxt.state = STIU_IDLE;
		endcase
	end

	// state register; the base update code rides in the struct
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= '{state: STIU_IDLE, err_kind: STIU_ERR_NONE, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	// stores never write flags
	assign flags_write_o  = 1'b0;
	assign bus.mem_valid  = (st_r.state == STIU_MEM);
	assign bus.aux_valid  = (st_r.state == STIU_AUX);
	assign bus.mem_addr   = st_r.addr;
	assign bus.mem_data   = st_r.data;
	assign bus.mem_size   = st_r.size;
	assign bus.mem_bypass = st_r.bypass;
	assign bus.aux_num    = st_r.addr;
	assign bus.aux_data   = st_r.data;
	assign inst_done_o    = st_r.done;
	assign err_o          = st_r.err;
	assign err_kind_o     = st_r.err_kind;
	assign wb_valid_o     = st_r.wb;
	assign wb_reg_o       = st_r.wb_reg;
	assign wb_data_o      = st_r.wb_data;
endmodule

// ---- bench/stiu_checker.sv ----
// checker on the store unit bus: answers, release, spacing, legal sizes
// assumes one core clock and an active-low asynchronous reset
module stiu_checker (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        mem_valid,
	input  wire logic        mem_ready,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_data,
	input  wire logic [1:0]  mem_size,
	input  wire logic        mem_bypass,
	input  wire logic        aux_valid,
	input  wire logic        aux_ready,
	input  wire logic [31:0] aux_num,
	input  wire logic [31:0] aux_data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// ************************************************
	// transfer steps
	// ************************************************
	sequence mem_take; mem_valid && mem_ready; endsequence
	sequence aux_take; aux_valid && aux_ready; endsequence
	size_legal_a: assert property (mem_valid |-> mem_size != 2'h3)
		else $error("reserved size on bus");
	one_target_a: assert property (!(mem_valid && aux_valid))
		else $error("memory and aux requests together");
	mem_answer_a: assert property (mem_valid |-> mem_ready)
		else $error("memory request not answered");
	aux_answer_a: assert property (aux_valid |-> aux_ready)
		else $error("aux request not answered");
	mem_release_a: assert property (mem_take |=> !mem_valid)
		else $error("memory request repeated");
	aux_release_a: assert property (aux_take |=> !aux_valid)
		else $error("aux request repeated");
	mem_gap_a: assert property ($rose(mem_valid) |-> !$past(aux_valid))
		else $error("memory request right behind aux");
	aux_gap_a: assert property ($rose(aux_valid) |-> !$past(mem_valid))
		else $error("aux request right behind memory");
endmodule

// ---- bench/tb_store_instruction_unit.sv ----
// bench: unit and target joined by the interface, user side driven here
// assumes the target answers at once; register values come straight from the bench
module tb_store_instruction_unit;
	timeunit 1ns;
	timeprecision 1ps;
	import stiu_pkg::*;
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        inst_valid_i = 1'b0;
	logic [31:0] inst_i = 32'h0;
	logic        inst_compact_i = 1'b0;
	logic [31:0] limm_i = 32'h0;
	logic [31:0] reg_b_i = 32'h0;
	logic [31:0] reg_c_i = 32'h0;
	logic        inst_ready_o, inst_done_o, err_o, wb_valid_o, flags_write_o;
	logic [1:0]  err_kind_o, got_size, got_kind;
	logic [4:0]  wb_reg_o, b_sel_o, c_sel_o, got_wbr;
	logic [31:0] wb_data_o, got_addr, got_data, got_wb;
	logic        got_byp, got_err, got_wbv, got_done;
	int          n_fail = 0;
	int          checks_done = 0;
	int          hits = 0;
	int          seen_n = 0;
	logic        tgt_seen, tgt_byp, tgt_mis;
	logic [1:0]  tgt_size;
	logic [31:0] tgt_addr, tgt_data;
	stiu_if stiu_if_i ();
	stiu_unit stiu_unit_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .inst_valid_i(inst_valid_i),
		.inst_i(inst_i), .inst_compact_i(inst_compact_i), .limm_i(limm_i), .reg_b_i(reg_b_i),
		.reg_c_i(reg_c_i), .inst_ready_o(inst_ready_o), .inst_done_o(inst_done_o),
		.err_o(err_o), .err_kind_o(err_kind_o), .wb_valid_o(wb_valid_o), .wb_reg_o(wb_reg_o),
		.wb_data_o(wb_data_o), .flags_write_o(flags_write_o), .b_sel_o(b_sel_o),
		.c_sel_o(c_sel_o), .bus(stiu_if_i.unit));
	stiu_target stiu_target_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(stiu_if_i.target),
		.wr_seen_o(tgt_seen), .last_addr_o(tgt_addr), .last_data_o(tgt_data),
		.last_size_o(tgt_size), .last_bypass_o(tgt_byp), .misalign_o(tgt_mis));
	stiu_checker stiu_checker_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.mem_valid(stiu_if_i.mem_valid), .mem_ready(stiu_if_i.mem_ready),
		.mem_addr(stiu_if_i.mem_addr), .mem_data(stiu_if_i.mem_data),
		.mem_size(stiu_if_i.mem_size), .mem_bypass(stiu_if_i.mem_bypass),
		.aux_valid(stiu_if_i.aux_valid), .aux_ready(stiu_if_i.aux_ready),
		.aux_num(stiu_if_i.aux_num), .aux_data(stiu_if_i.aux_data));
	// ************************************************
	// clock, monitor, reporting
	// ************************************************
	initial forever #4 clk_i = ~clk_i;
	// record accepted transfers and the completion pulse as sampled at the edge
	always @(posedge clk_i) begin
		if (tgt_seen === 1'b1) seen_n++;
		// a busy unit must not offer to take another instruction
		if (stiu_if_i.mem_valid === 1'b1 || stiu_if_i.aux_valid === 1'b1)
			ck(inst_ready_o !== 1'b0, "ready while busy");
		if (stiu_if_i.mem_valid && stiu_if_i.mem_ready) begin
			hits++;
			got_addr = stiu_if_i.mem_addr;
			got_data = stiu_if_i.mem_data;
			got_size = stiu_if_i.mem_size;
			got_byp = stiu_if_i.mem_bypass;
		end
		if (stiu_if_i.aux_valid && stiu_if_i.aux_ready) begin
			hits++;
			got_addr = stiu_if_i.aux_num;
			got_data = stiu_if_i.aux_data;
		end
		if (inst_done_o === 1'b1) begin
			got_done = 1'b1;
			got_err = err_o;
			got_kind = err_kind_o;
			got_wbv = wb_valid_o;
			got_wbr = wb_reg_o;
			got_wb = wb_data_o;
		end
	end
	task automatic finish_test();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic ck(input bit bad, input string m);
		checks_done++;
		if (bad) begin
			n_fail++;
			$display("unexpected %0t %s", $time, m);
		end
	endtask
	// offer one instruction, drop it after the taking edge, wait for done
	task automatic go(input logic [31:0] w, input logic cmp, input logic [31:0] b, c, l);
		@(posedge clk_i);
		ck(inst_ready_o !== 1'b1, "not ready when idle");
		inst_valid_i <= 1'b1;
		inst_i <= w;
		inst_compact_i <= cmp;
		limm_i <= l;
		reg_b_i <= b;
		reg_c_i <= c;
		hits = 0;
		seen_n = 0;
		got_done = 1'b0;
		@(posedge clk_i);
		inst_valid_i <= 1'b0;
		for (int i = 0; i < 20 && got_done !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
		end
		ck(seen_n !== hits, "target missed a write");
		ck(got_done !== 1'b1, "no completion");
		if (got_done !== 1'b1) finish_test();
	endtask
	// ************************************************
	// scenarios
	// ************************************************
	task automatic mem(input logic [8:0] s9, input logic di, input logic [1:0] aa, zz);
		logic [31:0] off, ea, msk, base;
		logic        mis;
		base = 32'hffff_fff0;
		off = {{23{s9[8]}}, s9};
		ea = (aa == STIU_UPD_POST) ? base : base + off;
		if (aa == STIU_UPD_SCALED) ea = base + (off << ((zz == STIU_SZ_LONG) ? 2 : 1));
		msk = (zz == STIU_SZ_LONG) ? 32'hffff_ffff : (zz == STIU_SZ_HALF) ? 32'hffff : 32'hff;
		mis = (zz == STIU_SZ_HALF && ea[0]) || (zz == STIU_SZ_LONG && ea[1:0] != 2'h0);
		go({5'h03, 3'h2, s9[7:0], s9[8], 3'h0, 6'h07, di, aa, zz, 1'b0}, 1'b0, base,
			32'hcafe_f00d, 32'h0);
		ck(hits !== 1 || got_addr !== ea || got_size !== zz, "store address");
		ck((got_data & msk) !== (32'hcafe_f00d & msk) || got_byp !== di, "store data");
		ck(got_wbv !== (aa == STIU_UPD_PRE || aa == STIU_UPD_POST), "base update");
		if (got_wbv === 1'b1) ck(got_wb !== base + off || got_wbr !== 5'h2, "update value");
		ck(b_sel_o !== 5'h02 || c_sel_o !== 5'h07, "register selects");
		ck(tgt_addr !== ea || tgt_size !== zz || tgt_byp !== di || tgt_mis !== mis ||
			(tgt_data & msk) !== (32'hcafe_f00d & msk), "target capture");
	endtask
	task automatic t_aux();
		go({5'h04, 3'h1, 2'h0, STIU_SUB_AUXW, 1'b0, 3'h0, 6'h02, 6'h2a}, 1'b0, 32'h1234_5678,
			32'h5, 32'h0);
		ck(hits !== 1 || got_data !== 32'h1234_5678 || got_addr !== 32'h5,
			"aux write");
		ck(flags_write_o !== 1'b0 || got_err !== 1'b0, "aux flags");
		// data from the long immediate, number from the six-bit field
		go({5'h04, 3'h6, 2'h1, STIU_SUB_AUXW, 1'b0, 3'h7, 6'h09, 6'h00}, 1'b0, 32'h1, 32'h5,
			32'h0bad_cafe);
		ck(hits !== 1 || got_data !== 32'h0bad_cafe || got_addr !== 32'h9,
			"aux limm data");
		// signed twelve-bit number, negative here
		go({5'h04, 3'h1, 2'h2, STIU_SUB_AUXW, 1'b0, 3'h0, 6'h30, 6'h3f}, 1'b0, 32'h77, 32'h5,
			32'h0);
		ck(hits !== 1 || got_data !== 32'h77 || got_addr !== 32'hffff_fff0,
			"aux signed number");
		go({5'h04, 3'h1, STIU_MODE_COND, STIU_SUB_AUXW, 1'b0, 3'h0, 6'h02, 6'h0}, 1'b0, 32'h1,
			32'h5, 32'h0);
		ck(hits !== 0 || got_err !== 1'b1 || got_kind !== 2'h1, "conditional aux");
	endtask
	task automatic t_mem();
		// every update code on a base near the top, so the sum wraps
		for (int a = 0; a < 4; a++) mem(9'h020, 1'b0, a[1:0], STIU_SZ_LONG);
		mem(9'h1f0, 1'b1, STIU_UPD_SCALED, STIU_SZ_HALF);
		mem(9'h004, 1'b1, STIU_UPD_NONE, STIU_SZ_BYTE);
		mem(9'h004, 1'b0, STIU_UPD_NONE, STIU_SZ_HALF);
		// odd half address: still stored, but the target must flag it
		mem(9'h001, 1'b0, STIU_UPD_NONE, STIU_SZ_HALF);
	endtask
	task automatic t_reserved();
		go({5'h03, 3'h2, 8'h04, 1'b0, 3'h0, 6'h07, 1'b0, 2'h0, 2'h3, 1'b0}, 1'b0, 32'h10, 32'h1,
			32'h0);
		ck(hits !== 0 || got_err !== 1'b1 || got_kind !== 2'h2, "reserved size");
		go({5'h03, 3'h2, 8'h04, 1'b0, 3'h0, 6'h07, 1'b0, 2'h3, 2'h1, 1'b0}, 1'b0, 32'h10, 32'h1,
			32'h0);
		ck(hits !== 0 || got_err !== 1'b1 || got_kind !== 2'h2, "scaled byte");
	endtask
	// a subtract word is no store: no bus transfer and no completion may follow, and the unit stays ready
	task automatic t_ignore();
		@(posedge clk_i);
		inst_valid_i <= 1'b1;
		inst_i <= {5'h04, 3'h1, 2'h0, 6'h02, 1'b0, 3'h0, 6'h03, 6'h04};
		inst_compact_i <= 1'b0;
		hits = 0;
		got_done = 1'b0;
		@(posedge clk_i);
		inst_valid_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		#1;
		ck(hits !== 0 || got_done !== 1'b0 || inst_ready_o !== 1'b1, "non-store taken");
	endtask
	task automatic t_compact(input logic [4:0] maj, input logic [2:0] sub, input logic [31:0] off,
			input logic [1:0] zz);
		logic sp;
		sp = (maj == STIU_MAJ_CSP);
		go({16'h0, maj, 3'h1, sub, 5'h03}, 1'b1, 32'h100, 32'h8765_4321, 32'h0);
		ck(hits !== 1 || got_addr !== 32'h100 + off || got_size !== zz,
			"compact store");
		ck(got_data !== 32'h8765_4321 || got_byp !== 1'b0 || got_wbv !== 1'b0,
			"compact data");
		ck(b_sel_o !== (sp ? STIU_SP_REG : 5'h01) || c_sel_o !== (sp ? 5'h01 : {2'h0, sub}),
			"compact selects");
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_aux();
		t_mem();
		t_reserved();
		t_ignore();
		t_compact(STIU_MAJ_CLONG, 3'h3, 32'hc, STIU_SZ_LONG);
		t_compact(STIU_MAJ_CBYTE, 3'h3, 32'h3, STIU_SZ_BYTE);
		t_compact(STIU_MAJ_CHALF, 3'h3, 32'h6, STIU_SZ_HALF);
		t_compact(STIU_MAJ_CSP, STIU_CSP_LONG, 32'hc, STIU_SZ_LONG);
		t_compact(STIU_MAJ_CSP, STIU_CSP_BYTE, 32'hc, STIU_SZ_BYTE);
		finish_test();
	end
endmodule
